// ===== bsn_shift_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Opcode 8 loads amount register A from the shift-value port at the closing edge.
// - Opcode 9 loads amount register B from the shift-value port at the closing edge.
// - During either load opcode the shifter output is the unshifted input.
// - Opcode A arithmetic-right-shifts the input by the 4-bit port value.
// - Opcode B arithmetic-right-shifts the input by amount register A.
// - Opcode C arithmetic-right-shifts the input by amount register B.
// - Every arithmetic right shift fills the vacated top bits with the original msb.
// - Opcodes D, E and F left-shift the input by the priority encoder count.
// - In a normalise the count is driven on the shift-value port only while its low enable is asserted.
// - The count is the left shift, at most 15, that makes the top two result bits differ.
// - Normalising drops the bits shifted out at the top and fills the bottom with zeros.
// - Opcode E also stores the count into amount register A at the closing edge.
// - Opcode F also stores the count into amount register B at the closing edge.
// - Opcode D leaves both amount registers unchanged.
module bsn_shift_top (
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	// wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [7:0]                  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output      logic [31:0]                 wb_dat_o,
	output      logic                        wb_ack_o,
	// shifter instruction and operand
	input  wire logic                        instr_valid_i,
	input  wire logic [3:0]                  instr_op_i,
	input  wire logic [bsn_pkg::DATA_W-1:0]  data_i,
	output      logic [bsn_pkg::DATA_W-1:0]  data_o,
	// shift-value port
	input  wire logic [bsn_pkg::AMT_W-1:0]   shift_value_port_i,
	output      logic [bsn_pkg::AMT_W-1:0]   shift_value_port_o,
	output      logic                        shift_value_port_oe_o,
	input  wire logic                        shift_value_out_enable_n_i
);
	import bsn_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [AMT_W-1:0]  amt_a;      // shift_amount_reg_a
		logic [AMT_W-1:0]  amt_b;      // shift_amount_reg_b
		logic [DATA_W-1:0] dout;       // registered shifter result
		logic [AMT_W-1:0]  last_cnt;   // count of last normalise
		logic [3:0]        last_op;    // last executed opcode
		logic              flat;       // last normalise saw no edge
		logic              exec_en;    // instructions take effect
		logic              ack;
		logic [31:0]       rdata;
	} bsn_state_s;

	bsn_state_s st_reg;
	bsn_state_s st_next;

	bsn_shift_if sh ();

	logic              exec;
	logic              is_load;
	logic              is_asr;
	logic              is_norm;
	logic              wb_req;
	logic              wb_wr;
	logic [5:0]        wb_word;
	logic [DATA_W-1:0] asr_ref;
	logic [DATA_W-1:0] asr_a_ref;
	logic [DATA_W-1:0] asr_b_ref;
	logic [DATA_W-1:0] norm_ref;

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	// software can park the block: instructions then have no effect
	assign exec    = instr_valid_i & st_reg.exec_en;
	assign is_load = (instr_op_i == OP_LOAD_A) |
	                 (instr_op_i == OP_LOAD_B);
	assign is_asr  = (instr_op_i == OP_ASR_PORT) |
	                 (instr_op_i == OP_ASR_A) |
	                 (instr_op_i == OP_ASR_B);
	assign is_norm = (instr_op_i == OP_NORM_ONLY) |
	                 (instr_op_i == OP_NORM_A) |
	                 (instr_op_i == OP_NORM_B);

	// ----------------------------------------------------------------
	// shifter and encoder
	// ----------------------------------------------------------------
	bsn_shifter u_shifter (
		.sh (sh.shifter)
	);

	bsn_norm_enc u_enc (
		.en (sh.encoder)
	);

	// operand straight from the data input, outside the loop below
	assign sh.din = data_i;

	// shift direction and amount selection
	always_comb begin
		sh.left = is_norm;
		case (instr_op_i)
			OP_ASR_PORT: sh.amt = shift_value_port_i;
			OP_ASR_A:    sh.amt = st_reg.amt_a;
			OP_ASR_B:    sh.amt = st_reg.amt_b;
			OP_NORM_ONLY,
			OP_NORM_A,
			OP_NORM_B:   sh.amt = sh.cnt;
			default:     sh.amt = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// shift-value port drive
	// ----------------------------------------------------------------
	// count leaves only in a normalise with the low enable asserted
	assign shift_value_port_o    = sh.cnt;
	assign shift_value_port_oe_o = exec & is_norm &
	                               ~shift_value_out_enable_n_i;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// write lands at the edge where ack is already high
	assign wb_req  = wb_cyc_i & wb_stb_i;
	assign wb_wr   = wb_req & wb_we_i & st_reg.ack;
	assign wb_word = wb_adr_i[7:2];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next     = st_reg;
		st_next.ack = wb_req & ~st_reg.ack;

		// register reads, sampled with the rising ack
		if (wb_req & ~st_reg.ack) begin
			st_next.rdata = '0;
			case (wb_word)
				REG_CTRL[7:2]: begin
					st_next.rdata[CTRL_EN_BIT] = st_reg.exec_en;
				end
				REG_AMOUNT[7:2]: begin
					st_next.rdata[AMT_A_LSB +: AMT_W] = st_reg.amt_a;
					st_next.rdata[AMT_B_LSB +: AMT_W] = st_reg.amt_b;
				end
				REG_STATUS[7:2]: begin
					st_next.rdata[ST_CNT_LSB +: AMT_W] = st_reg.last_cnt;
					st_next.rdata[ST_OP_LSB +: 4]      = st_reg.last_op;
					st_next.rdata[ST_FLAT_BIT]         = st_reg.flat;
				end
				default: begin
					st_next.rdata = '0;
				end
			endcase
		end

		// register writes; status and unmapped words ignore them
		if (wb_wr) begin
			case (wb_word)
				REG_CTRL[7:2]: begin
					if (wb_sel_i[0]) begin
						st_next.exec_en = wb_dat_i[CTRL_EN_BIT];
					end
				end
				REG_AMOUNT[7:2]: begin
					if (wb_sel_i[0]) begin
						st_next.amt_a = wb_dat_i[AMT_A_LSB +: AMT_W];
					end
					if (wb_sel_i[1]) begin
						st_next.amt_b = wb_dat_i[AMT_B_LSB +: AMT_W];
					end
				end
				default: begin
					st_next.rdata = st_reg.rdata;
				end
			endcase
		end

		// instruction execution; hardware loads win over the bus
		if (exec) begin
			st_next.last_op = instr_op_i;
			if (is_load | is_asr | is_norm) begin
				st_next.dout = sh.dout;
			end else begin
				st_next.dout = data_i;
			end
			if (is_norm) begin
				st_next.last_cnt = sh.cnt;
				st_next.flat     = (sh.cnt == MAX_CNT) &
				                   (data_i[0] == data_i[DATA_W-1]);
			end
			case (instr_op_i)
				OP_LOAD_A: st_next.amt_a = shift_value_port_i;
				OP_LOAD_B: st_next.amt_b = shift_value_port_i;
				OP_NORM_A: st_next.amt_a = sh.cnt;
				OP_NORM_B: st_next.amt_b = sh.cnt;
				default: begin
					st_next.amt_a = st_next.amt_a;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg          <= '0;
			st_reg.amt_a    <= AMT_RST;
			st_reg.amt_b    <= AMT_RST;
			st_reg.exec_en  <= CTRL_EN_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs
	assign data_o   = st_reg.dout;
	assign wb_dat_o = st_reg.rdata;
	assign wb_ack_o = st_reg.ack;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// independent reference for the port-amount right shift
	assign asr_ref = DATA_W'($signed(data_i) >>> shift_value_port_i);

	// held-amount right shifts and the normalise left shift
	assign asr_a_ref = DATA_W'($signed(data_i) >>> st_reg.amt_a);
	assign asr_b_ref = DATA_W'($signed(data_i) >>> st_reg.amt_b);
	assign norm_ref  = DATA_W'(data_i << shift_value_port_o);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_load_amt_a: assert property (
		exec && instr_op_i == OP_LOAD_A
		|=> st_reg.amt_a == $past(shift_value_port_i))
	else $error("amount a not loaded from port");

	a_load_amt_b: assert property (
		exec && instr_op_i == OP_LOAD_B
		|=> st_reg.amt_b == $past(shift_value_port_i))
	else $error("amount b not loaded from port");

	a_load_passes: assert property (
		exec && is_load |=> data_o == $past(data_i))
	else $error("load opcode altered the data");

	a_asr_port: assert property (
		exec && instr_op_i == OP_ASR_PORT |=> data_o == $past(asr_ref))
	else $error("port-amount right shift wrong");

	a_asr_amt_a: assert property (
		exec && instr_op_i == OP_ASR_A |=> data_o == $past(asr_a_ref))
	else $error("amount-a right shift wrong");

	a_asr_amt_b: assert property (
		exec && instr_op_i == OP_ASR_B |=> data_o == $past(asr_b_ref))
	else $error("amount-b right shift wrong");

	a_asr_sign: assert property (
		exec && is_asr |=> data_o[DATA_W-1] == $past(data_i[DATA_W-1]))
	else $error("right shift lost the sign");

	a_sv_drive: assert property (
		shift_value_port_oe_o
		|-> is_norm && !shift_value_out_enable_n_i && instr_valid_i)
	else $error("shift-value port driven outside normalise");

	a_sv_enable: assert property (
		exec && is_norm && !shift_value_out_enable_n_i
		|-> shift_value_port_oe_o)
	else $error("shift-value port not driven in normalise");

	a_norm_shift: assert property (
		exec && is_norm |=> data_o == $past(norm_ref))
	else $error("normalise shift wrong");

	a_norm_result: assert property (
		exec && is_norm && data_i != '0 && data_i != '1
		|=> data_o[DATA_W-1] != data_o[DATA_W-2])
	else $error("normalised top bits equal");

	a_norm_zero_fill: assert property (
		exec && is_norm && sh.cnt != '0 |=> data_o[0] == 1'b0)
	else $error("normalise did not zero fill");

	a_norm_store_a: assert property (
		exec && instr_op_i == OP_NORM_A
		|=> st_reg.amt_a == $past(shift_value_port_o))
	else $error("count not stored in amount a");

	a_norm_store_b: assert property (
		exec && instr_op_i == OP_NORM_B
		|=> st_reg.amt_b == $past(shift_value_port_o))
	else $error("count not stored in amount b");

	a_norm_a_keeps_b: assert property (
		exec && instr_op_i == OP_NORM_A && !wb_wr
		|=> $stable(st_reg.amt_b))
	else $error("normalise into a changed amount b");

	a_norm_b_keeps_a: assert property (
		exec && instr_op_i == OP_NORM_B && !wb_wr
		|=> $stable(st_reg.amt_a))
	else $error("normalise into b changed amount a");

	a_norm_only_hold: assert property (
		exec && instr_op_i == OP_NORM_ONLY && !wb_wr
		|=> $stable(st_reg.amt_a) && $stable(st_reg.amt_b))
	else $error("normalise-only changed an amount");

	a_norm_flat: assert property (
		is_norm && (data_i == '0 || data_i == '1)
		|-> shift_value_port_o == MAX_CNT)
	else $error("flat operand count not fifteen");

	c_load_then_asr: cover property (
		exec && instr_op_i == OP_LOAD_A ##1 exec && instr_op_i == OP_ASR_A);
	c_norm_driven: cover property (shift_value_port_oe_o);
	c_norm_store_b: cover property (exec && instr_op_i == OP_NORM_B);
	c_bus_write: cover property (wb_wr && wb_word == REG_AMOUNT[7:2]);
	c_flat_norm: cover property (exec && is_norm &&
		shift_value_port_o == MAX_CNT);

endmodule // bsn_shift_top

// ===== bsn_pkg.sv
package bsn_pkg;

	// ----------------------------------------------------------------
	// datapath widths
	// ----------------------------------------------------------------
	localparam int          DATA_W  = 16;
	localparam int          AMT_W   = 4;
	localparam logic [3:0]  MAX_CNT = 4'hF;   // encoder ceiling

	// ----------------------------------------------------------------
	// shifter opcodes handled here
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_LOAD_A     = 4'h8; // load_amount_a_from_port
	localparam logic [3:0] OP_LOAD_B     = 4'h9; // load_amount_b_from_port
	localparam logic [3:0] OP_ASR_PORT   = 4'hA; // arith_right_by_port_value
	localparam logic [3:0] OP_ASR_A      = 4'hB; // arith_right_by_amount_a
	localparam logic [3:0] OP_ASR_B      = 4'hC; // arith_right_by_amount_b
	localparam logic [3:0] OP_NORM_ONLY  = 4'hD; // normalise_only
	localparam logic [3:0] OP_NORM_A     = 4'hE; // normalise_store_amount_a
	localparam logic [3:0] OP_NORM_B     = 4'hF; // normalise_store_amount_b

	// ----------------------------------------------------------------
	// register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_AMOUNT  = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;
	localparam int         CTRL_EN_BIT = 0;
	localparam int         AMT_A_LSB   = 0;
	localparam int         AMT_B_LSB   = 8;
	localparam int         ST_CNT_LSB  = 0;
	localparam int         ST_OP_LSB   = 8;
	localparam int         ST_FLAT_BIT = 16;
	localparam logic       CTRL_EN_RST = 1'b1;
	localparam logic [3:0] AMT_RST     = 4'h0;

endpackage

// ===== bsn_shift_if.sv
`timescale 1ns/1ps
interface bsn_shift_if;
	import bsn_pkg::*;

	// ----------------------------------------------------------------
	// shifter request, result and encoder count
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] din;
	logic [AMT_W-1:0]  amt;
	logic              left;
	logic [DATA_W-1:0] dout;
	logic [AMT_W-1:0]  cnt;

	modport shifter (input din, input amt, input left, output dout);
	modport encoder (input din, output cnt);
	modport user    (output din, output amt, output left,
	                 input dout, input cnt);
endinterface

// ===== bsn_shifter.sv
`timescale 1ns/1ps
module bsn_shifter (
	// shift request and result
	bsn_shift_if.shifter sh
);
	import bsn_pkg::*;

	// ----------------------------------------------------------------
	// arithmetic right or zero-filling left shift
	// ----------------------------------------------------------------
	// right: vacated top bits copy the original msb
	// left: top bits drop out, low bits fill with zero
	always_comb begin
		for (int i = 0; i < DATA_W; i++) begin
			if (sh.left) begin
				sh.dout[i] = (i >= int'(sh.amt)) ?
					sh.din[i - int'(sh.amt)] : 1'b0;
			end else begin
				sh.dout[i] = (i + int'(sh.amt) < DATA_W) ?
					sh.din[i + int'(sh.amt)] : sh.din[DATA_W-1];
			end
		end
	end

endmodule // bsn_shifter

// ===== bsn_norm_enc.sv
`timescale 1ns/1ps
module bsn_norm_enc (
	// operand in, count out
	bsn_shift_if.encoder en
);
	import bsn_pkg::*;

	// ----------------------------------------------------------------
	// priority encoder
	// ----------------------------------------------------------------
	// highest bit that differs from the msb sets the count;
	// a flat operand has none and reports the ceiling
	always_comb begin
		en.cnt = MAX_CNT;
		for (int i = 0; i < DATA_W - 1; i++) begin
			if (en.din[i] != en.din[DATA_W-1]) begin
				en.cnt = AMT_W'(DATA_W - 2 - i);
			end
		end
	end

endmodule // bsn_norm_enc

// ===== bsn_ctl_model.sv
`timescale 1ns/1ps
module bsn_ctl_model (
	// clock and control
	input  wire logic                      clk_i,
	input  wire logic                      drive_i,
	input  wire logic [bsn_pkg::AMT_W-1:0] val_i,
	// device side of the port
	input  wire logic                      dev_oe_i,
	input  wire logic [bsn_pkg::AMT_W-1:0] dev_val_i,
	// resolved port level
	output      logic [bsn_pkg::AMT_W-1:0] port_o
);
	import bsn_pkg::*;

	logic [AMT_W-1:0] last_reg = 4'h0;

	// let go while the device drives, float to a changing level when idle
	always_comb begin
		if (dev_oe_i)
			port_o = dev_val_i;
		else if (drive_i)
			port_o = val_i;
		else
			port_o = ~last_reg;
	end

	// last level, so a floating port never repeats it
	always_ff @(posedge clk_i) begin
		last_reg <= port_o;
	end
endmodule // bsn_ctl_model

// ===== barrel_shift_normalize_ops_tb.sv
`timescale 1ns/1ps
module barrel_shift_normalize_ops_tb;
	import bsn_pkg::*;

	// ----------------------------------------------------------------
	// signals and model state
	// ----------------------------------------------------------------
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, oe;
	logic        vld = 1'b0, oen = 1'b1, drv = 1'b1;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [3:0]  op = 4'h0, sv = 4'h0, port, pout;
	logic [15:0] din = 16'h0, dout, exp_d = 16'h0, d;
	int          errors = 0, n_checks = 0, seed = 32'hc27d, tick = 0;
	int          ma = 0, mb = 0, men = 1;

	always #10 clk_i = ~clk_i;

	bsn_shift_top bsn_shift_top_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .instr_valid_i(vld),
		.instr_op_i(op), .data_i(din), .data_o(dout),
		.shift_value_port_i(port), .shift_value_port_o(pout),
		.shift_value_port_oe_o(oe), .shift_value_out_enable_n_i(oen));

	bsn_ctl_model bsn_ctl_model_i (
		.clk_i(clk_i), .drive_i(drv), .val_i(sv), .dev_oe_i(oe),
		.dev_val_i(pout), .port_o(port));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic int enc(input logic [15:0] x);
		for (int i = 14; i >= 0; i--)
			if (x[i] != x[15])
				return 14 - i;
		return 15;
	endfunction

	// one classic wishbone cycle, waits for ack
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] dw, output logic [31:0] r);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= dw;
		do @(posedge clk_i); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// issue one instruction; result of the one before is checked here
	task automatic ex(input logic [3:0] o, input logic [15:0] x,
		input logic [3:0] s, input logic n);
		int c;
		@(posedge clk_i);
		vld <= 1'b1;
		op <= o;
		din <= x;
		sv <= s;
		oen <= n;
		drv <= (o < OP_NORM_ONLY);
		#1;
		chk("data_o", exp_d, dout); // previous result
		c = enc(x);
		chk("oe", men != 0 && o >= OP_NORM_ONLY && !n, oe);
		if (o >= OP_NORM_ONLY)
			chk("count", c, pout);
		if (men != 0) begin
			exp_d = x;
			case (o)
				OP_LOAD_A: ma = s;
				OP_LOAD_B: mb = s;
				OP_ASR_PORT: exp_d = $signed(x) >>> s;
				OP_ASR_A: exp_d = $signed(x) >>> ma;
				OP_ASR_B: exp_d = $signed(x) >>> mb;
				default: if (o >= OP_NORM_ONLY) exp_d = x << c;
			endcase
			if (o == OP_NORM_A)
				ma = c;
			if (o == OP_NORM_B)
				mb = c;
		end
	endtask

	task automatic idle();
		@(posedge clk_i);
		vld <= 1'b0;
		#1;
		chk("data_o", exp_d, dout); // last result
	endtask

	task automatic amt_chk();
		wb(1'b0, REG_AMOUNT, 32'h0, q);
		chk("amount", {20'h0, mb[3:0], 4'h0, ma[3:0]}, q);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard
	always @(posedge clk_i) begin
		tick++;
		if (tick == 5000) begin
			errors++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, REG_CTRL, 32'h0, q);
		chk("ctrl", 32'h1, q);
		amt_chk();
		wb(1'b1, 8'hFC, 32'hFFFF_FFFF, q);
		wb(1'b0, 8'hFC, 32'h0, q);
		chk("unmapped", 32'h0, q);
		$display("test registers done");
		// every opcode back to back, with flat operands now and then
		for (int r = 0; r < 96; r++) begin
			d = $random(seed);
			if (r % 16 == 7)
				d = {16{r[4]}};
			ex({1'b1, r[2:0]}, d, $random(seed), $random(seed));
		end
		idle();
		amt_chk();
		$display("test opcodes done");
		// amounts set over the bus, extreme shift counts
		wb(1'b1, REG_AMOUNT, 32'h0000_0F01, q);
		ma = 1;
		mb = 15;
		ex(OP_ASR_A, 16'h8000, 4'h0, 1'b1);
		ex(OP_ASR_B, 16'h8000, 4'h0, 1'b1);
		ex(OP_ASR_PORT, 16'h7FFF, 4'hF, 1'b1);
		ex(4'h5, 16'hA5A5, 4'h3, 1'b0);
		ex(OP_NORM_ONLY, 16'h0001, 4'h0, 1'b0);
		idle();
		amt_chk();
		wb(1'b0, REG_STATUS, 32'h0, q);
		chk("status", 32'h0000_0D0E, q);
		$display("test amounts done");
		// execution disabled: nothing moves
		wb(1'b1, REG_CTRL, 32'h0, q);
		men = 0;
		ex(OP_LOAD_A, 16'h1234, 4'h7, 1'b0);
		ex(OP_NORM_B, 16'h0003, 4'h0, 1'b0);
		idle();
		amt_chk();
		wb(1'b0, REG_STATUS, 32'h0, q);
		chk("status held", 32'h0000_0D0E, q);
		wb(1'b1, REG_CTRL, 32'h1, q);
		men = 1;
		$display("test disable done");
		results();
	end
endmodule // barrel_shift_normalize_ops_tb
